// ### fp_cfg.svh
/*
  Constants for the frame pulse and forwarding register bank:
  register indices, field positions, reset values, bus answers.
  Assumes inclusion by bare name from each file that uses it.
*/
`ifndef FP_CFG_SVH
`define FP_CFG_SVH

`define IDX_PULSE_CTL      8'h18
`define IDX_HI_PERIOD_MSB  8'h19
`define IDX_HI_PERIOD_LSB  8'h1A
`define IDX_LO_PERIOD_MSB  8'h1B
`define IDX_LO_PERIOD_LSB  8'h1C
`define IDX_LIMIT_HIGH     8'h1D
`define IDX_LIMIT_LOW      8'h1E
`define IDX_RATE_CTL       8'h1F
`define IDX_FWD_DISABLE    8'h20

`define RST_BYTE_ZERO      8'h00
`define RST_LIMIT_HIGH     8'h00
`define RST_LIMIT_LOW      8'h04
`define RST_RATE           2'h2
`define RST_FWD_RSVD       2'h0
`define RST_FWD_OFF        1'b1

`define BIT_SOURCE_MSB     7
`define BIT_SOURCE_LSB     4
`define BIT_ONE_SHOT       3
`define BIT_IDLE_LEVEL     2
`define BIT_DUTY_MODE      1
`define BIT_GEN_ON         0
`define BIT_FWD_RSVD_MSB   7
`define BIT_FWD_RSVD_LSB   6
`define BIT_PORT1_OFF      5
`define BIT_PORT0_OFF      4
`define BIT_RATE_RSVD_MSB  3
`define BIT_RATE_RSVD_LSB  2
`define BIT_RATE_MSB       1

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ### fp_pkg.sv
/*
  Types shared by the frame pulse and forwarding register bank.
  Assumes nothing of its surroundings.
*/
package fp_pkg;
  typedef enum logic [2:0] {
    PG_IDLE = 3'h1,
    PG_RUN  = 3'h2,
    PG_SHOT = 3'h4
  } pulse_state_t;

  typedef enum logic [1:0] {
    RATE_1G6  = 2'h0,
    RATE_RSVD = 2'h1,
    RATE_800M = 2'h2,
    RATE_400M = 2'h3
  } tx_rate_t;
endpackage

// ### frame_counter.sv
/*
  Frame number for raw-mode frame start and end packets.
  Assumes frame_start is a one-cycle pulse on aclk.
*/
module frame_counter
(
  input  wire logic        aclk,         // system clock
  input  wire logic        aresetn,      // sync reset, active low
  input  wire logic        frame_start,  // new frame begins
  input  wire logic [15:0] limit,        // highest frame number
  output logic      [15:0] frame_number  // number for start and end packets
);
  logic [15:0] num_r;

  assign frame_number = num_r;

  // number is held from frame start through frame end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      num_r <= 16'h0000;
    else if (frame_start)
    begin
      if (limit == 16'h0000)
        num_r <= 16'h0000;
      else if (num_r >= limit || num_r == 16'h0000)
        num_r <= 16'h0001;
      else
        num_r <= num_r + 16'h0001;
    end
  end

  number_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_start && limit == 16'h0000 |=> frame_number == 16'h0000)
    else $error("frame number not zero while disabled");

  number_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_start && limit != 16'h0000 && frame_number >= limit |=> frame_number == 16'h0001)
    else $error("frame number did not return to one");

  number_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_start && limit != 16'h0000 && frame_number < limit && frame_number != 16'h0000
      |=> frame_number == $past(frame_number) + 16'h0001)
    else $error("frame number did not advance");
endmodule // frame_counter

// ### frame_pulse_and_forwarding_regs.sv
/*
  Register bank for the frame pulse generator, frame numbering,
  transmitter rate select and per-port forwarding disables, reached
  over an AXI4-Lite slave. Assumes ref_tick, frame_start and
  frame_end come from logic on aclk.
*/
`include "fp_cfg.svh"

module frame_pulse_and_forwarding_regs
  import fp_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              aclk,              // system clock, 40 MHz
  input  wire logic              aresetn,           // sync reset, active low
  input  wire logic [ADDR_W-1:0] awaddr,            // write address
  input  wire logic [2:0]        awprot,            // unused protection
  input  wire logic              awvalid,           // write address valid
  output logic                   awready,           // write address ready
  input  wire logic [31:0]       wdata,             // write data
  input  wire logic [3:0]        wstrb,             // byte strobes
  input  wire logic              wvalid,            // write data valid
  output logic                   wready,            // write data ready
  output logic [1:0]             bresp,             // write response
  output logic                   bvalid,            // write response valid
  input  wire logic              bready,            // write response ready
  input  wire logic [ADDR_W-1:0] araddr,            // read address
  input  wire logic [2:0]        arprot,            // unused protection
  input  wire logic              arvalid,           // read address valid
  output logic                   arready,           // read address ready
  output logic [31:0]            rdata,             // read data
  output logic [1:0]             rresp,             // read response
  output logic                   rvalid,            // read data valid
  input  wire logic              rready,            // read data ready
  input  wire logic              ref_tick,          // reference cycle enable
  input  wire logic              frame_start,       // raw frame begins
  input  wire logic              frame_end,         // raw frame ends
  output logic                   frame_pulse,       // generated frame pulse
  output logic [15:0]            frame_number,      // start/end packet number
  output logic [1:0]             tx_rate,           // lane rate select
  output logic                   port0_forward_off, // stop port 0 video
  output logic                   port1_forward_off  // stop port 1 video
);
  logic              aw_held_r;
  logic              w_held_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wbyte_r;
  logic              wlane_r;
  logic              aw_held_nxt;
  logic              w_held_nxt;
  logic              rvalid_nxt;
  logic              wr_go;
  logic              wr_en;
  logic [7:0]        wr_idx;
  logic [7:0]        rd_idx;
  logic [7:0]        rd_byte;

  logic [3:0]        source_r;
  logic              gen_on_r;
  logic              duty_mode_r;
  logic              idle_level_r;
  logic              shot_r;
  logic [7:0]        hi_msb_r;
  logic [7:0]        hi_lsb_r;
  logic [7:0]        lo_msb_r;
  logic [7:0]        lo_lsb_r;
  logic [7:0]        limit_hi_r;
  logic [7:0]        limit_lo_r;
  logic [1:0]        rate_rsvd_r;
  logic [1:0]        rate_field_r;
  tx_rate_t          tx_rate_r;
  logic [1:0]        fwd_rsvd_r;
  logic              port0_off_r;
  logic              port1_off_r;

  pulse_cfg_if pcfg ();

  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = 8'(addr[ADDR_W-1:2]);
  endfunction

  function automatic logic reg_known(input logic [7:0] idx);
    reg_known = (idx >= `IDX_PULSE_CTL) && (idx <= `IDX_FWD_DISABLE);
  endfunction

  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;

  assign wr_idx      = reg_index(awaddr_r);
  assign rd_idx      = reg_index(araddr);
  assign wr_go       = aw_held_r && w_held_r && !bvalid_r;
  assign wr_en       = wr_go && wlane_r && reg_known(wr_idx);
  assign aw_held_nxt = (aw_held_r || (awvalid && awready_r)) && !wr_go;
  assign w_held_nxt  = (w_held_r || (wvalid && wready_r)) && !wr_go;
  assign rvalid_nxt  = (arvalid && arready_r) || (rvalid_r && !rready);

  // address and data are taken in either order, then committed together
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      awaddr_r  <= '0;
      wbyte_r   <= 8'h00;
      wlane_r   <= 1'b0;
    end
    else
    begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awready_r <= !aw_held_nxt;
      wready_r  <= !w_held_nxt;
      if (awvalid && awready_r)
        awaddr_r <= awaddr;
      if (wvalid && wready_r)
      begin
        wbyte_r <= wdata[7:0];
        wlane_r <= wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= reg_known(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bready)
      bvalid_r <= 1'b0;
  end

  always_comb
  begin
    case (rd_idx)
      `IDX_PULSE_CTL:     rd_byte = {source_r, 1'b0, idle_level_r, duty_mode_r, gen_on_r};
      `IDX_HI_PERIOD_MSB: rd_byte = hi_msb_r;
      `IDX_HI_PERIOD_LSB: rd_byte = hi_lsb_r;
      `IDX_LO_PERIOD_MSB: rd_byte = lo_msb_r;
      `IDX_LO_PERIOD_LSB: rd_byte = lo_lsb_r;
      `IDX_LIMIT_HIGH:    rd_byte = limit_hi_r;
      `IDX_LIMIT_LOW:     rd_byte = limit_lo_r;
      `IDX_RATE_CTL:      rd_byte = {4'h0, rate_rsvd_r, rate_field_r};
      `IDX_FWD_DISABLE:   rd_byte = {fwd_rsvd_r, port1_off_r, port0_off_r, 4'h0};
      default:            rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= `RESP_OKAY;
      rdata_r   <= 32'h00000000;
    end
    else
    begin
      arready_r <= !rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (arvalid && arready_r)
      begin
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= reg_known(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // pulse generator control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      source_r     <= 4'h0;
      gen_on_r     <= 1'b0;
      duty_mode_r  <= 1'b0;
      idle_level_r <= 1'b0;
      shot_r       <= 1'b0;
    end
    else
    begin
      shot_r <= 1'b0;
      if (wr_en && wr_idx == `IDX_PULSE_CTL)
      begin
        source_r     <= wbyte_r[`BIT_SOURCE_MSB:`BIT_SOURCE_LSB];
        gen_on_r     <= wbyte_r[`BIT_GEN_ON];
        duty_mode_r  <= wbyte_r[`BIT_DUTY_MODE];
        idle_level_r <= wbyte_r[`BIT_IDLE_LEVEL];
        shot_r       <= wbyte_r[`BIT_ONE_SHOT];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hi_msb_r <= `RST_BYTE_ZERO;
      hi_lsb_r <= `RST_BYTE_ZERO;
      lo_msb_r <= `RST_BYTE_ZERO;
      lo_lsb_r <= `RST_BYTE_ZERO;
    end
    else if (wr_en)
    begin
      if (wr_idx == `IDX_HI_PERIOD_MSB)
        hi_msb_r <= wbyte_r;
      if (wr_idx == `IDX_HI_PERIOD_LSB)
        hi_lsb_r <= wbyte_r;
      if (wr_idx == `IDX_LO_PERIOD_MSB)
        lo_msb_r <= wbyte_r;
      if (wr_idx == `IDX_LO_PERIOD_LSB)
        lo_lsb_r <= wbyte_r;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      limit_hi_r <= `RST_LIMIT_HIGH;
      limit_lo_r <= `RST_LIMIT_LOW;
    end
    else if (wr_en)
    begin
      if (wr_idx == `IDX_LIMIT_HIGH)
        limit_hi_r <= wbyte_r;
      if (wr_idx == `IDX_LIMIT_LOW)
        limit_lo_r <= wbyte_r;
    end
  end

  // the reserved code is stored for readback but never reaches the transmitter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rate_rsvd_r  <= 2'h0;
      rate_field_r <= `RST_RATE;
      tx_rate_r    <= RATE_800M;
    end
    else if (wr_en && wr_idx == `IDX_RATE_CTL)
    begin
      rate_rsvd_r  <= wbyte_r[`BIT_RATE_RSVD_MSB:`BIT_RATE_RSVD_LSB];
      rate_field_r <= wbyte_r[`BIT_RATE_MSB:0];
      if (tx_rate_t'(wbyte_r[`BIT_RATE_MSB:0]) != RATE_RSVD)
        tx_rate_r <= tx_rate_t'(wbyte_r[`BIT_RATE_MSB:0]);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fwd_rsvd_r  <= `RST_FWD_RSVD;
      port1_off_r <= `RST_FWD_OFF;
      port0_off_r <= `RST_FWD_OFF;
    end
    else if (wr_en && wr_idx == `IDX_FWD_DISABLE)
    begin
      fwd_rsvd_r  <= wbyte_r[`BIT_FWD_RSVD_MSB:`BIT_FWD_RSVD_LSB];
      port1_off_r <= wbyte_r[`BIT_PORT1_OFF];
      port0_off_r <= wbyte_r[`BIT_PORT0_OFF];
    end
  end

  assign tx_rate           = tx_rate_r;
  assign port0_forward_off = port0_off_r;
  assign port1_forward_off = port1_off_r;

  assign pcfg.gen_on      = gen_on_r;
  assign pcfg.duty_mode   = duty_mode_r;
  assign pcfg.idle_level  = idle_level_r;
  assign pcfg.shot        = shot_r;
  assign pcfg.ref_tick    = ref_tick;
  assign pcfg.high_period = {hi_msb_r, hi_lsb_r};
  assign pcfg.low_period  = {lo_msb_r, lo_lsb_r};

  pulse_gen u_pulse_gen
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .cfg         (pcfg),
    .frame_pulse (frame_pulse)
  );

  // frame_end needs no action: the end packet reuses the start number
  frame_counter u_frame_counter
  (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .frame_start  (frame_start),
    .limit        ({limit_hi_r, limit_lo_r}),
    .frame_number (frame_number)
  );

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

  rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");

  fwd_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && wr_idx == `IDX_FWD_DISABLE |=> port1_forward_off == $past(wbyte_r[`BIT_PORT1_OFF])
      && port0_forward_off == $past(wbyte_r[`BIT_PORT0_OFF]))
    else $error("forwarding disables not updated");

  rate_legal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_rate != RATE_RSVD)
    else $error("reserved rate reached the transmitter");

  rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready && reg_index(araddr) == `IDX_FWD_DISABLE |=> rdata[3:0] == 4'h0)
    else $error("read-only reserved bits not zero");

  shot_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    shot_r |=> !shot_r)
    else $error("one-shot request held longer than a cycle");
endmodule // frame_pulse_and_forwarding_regs

// ### pulse_cfg_if.sv
/*
  Configuration bundle from the register bank to the pulse generator.
  Assumes both ends run on the same clock.
*/
interface pulse_cfg_if;
  logic        gen_on;
  logic        duty_mode;
  logic        idle_level;
  logic        shot;
  logic        ref_tick;
  logic [15:0] high_period;
  logic [15:0] low_period;

  modport ctl (output gen_on, duty_mode, idle_level, shot, ref_tick, high_period, low_period);
  modport gen (input gen_on, duty_mode, idle_level, shot, ref_tick, high_period, low_period);
endinterface

// ### pulse_gen.sv
/*
  Frame pulse generator: down-counter advanced by reference ticks.
  Assumes ref_tick is a one-cycle enable on aclk.
*/
`include "fp_cfg.svh"
module pulse_gen
  import fp_pkg::*;
(
  input  wire logic  aclk,        // system clock
  input  wire logic  aresetn,     // sync reset, active low
  pulse_cfg_if.gen   cfg,         // settings from registers
  output logic       frame_pulse  // generated pulse
);
  pulse_state_t state_r;
  logic [23:0]  cnt_r;
  logic         level_r;
  logic [23:0]  len_high;
  logic [23:0]  len_low;

  function automatic logic [23:0] phase_len(input logic equal, input logic high,
                                            input logic [15:0] hp, input logic [15:0] lp);
    if (equal)
      phase_len = {hp[7:0], lp};
    else if (high)
      phase_len = {8'h00, hp};
    else
      phase_len = {8'h00, lp};
  endfunction

  assign len_high    = phase_len(cfg.duty_mode, 1'b1, cfg.high_period, cfg.low_period);
  assign len_low     = phase_len(cfg.duty_mode, 1'b0, cfg.high_period, cfg.low_period);
  assign frame_pulse = level_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= PG_IDLE;
      cnt_r   <= 24'h000000;
      level_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        PG_IDLE:
        begin
          level_r <= cfg.idle_level;
          if (cfg.shot)
          begin
            state_r <= PG_SHOT;
            level_r <= 1'b1;
            cnt_r   <= len_high;
          end
          else if (cfg.gen_on)
          begin
            state_r <= PG_RUN;
            cnt_r   <= cfg.idle_level ? len_high : len_low;
          end
        end
        PG_RUN:
        begin
          if (!cfg.gen_on)
            state_r <= PG_IDLE;
          else if (cfg.ref_tick)
          begin
            if (cnt_r == 24'h000000)
            begin
              level_r <= ~level_r;
              cnt_r   <= level_r ? len_low : len_high;
            end
            else
              cnt_r <= cnt_r - 24'h000001;
          end
        end
        PG_SHOT:
        begin
          // one shot ignores gen_on; software keeps generation off meanwhile
          if (cfg.ref_tick)
          begin
            if (cnt_r == 24'h000000)
            begin
              state_r <= PG_IDLE;
              level_r <= cfg.idle_level;
            end
            else
              cnt_r <= cnt_r - 24'h000001;
          end
        end
        default: state_r <= PG_IDLE;
      endcase
    end
  end

  toggle_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == PG_RUN && cfg.gen_on && cfg.ref_tick && cnt_r == 24'h000000
      |=> level_r != $past(level_r))
    else $error("pulse did not toggle at phase end");

  high_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == PG_RUN && cfg.gen_on && cfg.ref_tick && cnt_r == 24'h000000 && !level_r
      |=> cnt_r == $past(len_high) && level_r)
    else $error("high phase reloaded with wrong length");

  low_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == PG_RUN && cfg.gen_on && cfg.ref_tick && cnt_r == 24'h000000 && level_r
      && !cfg.duty_mode |=> cnt_r == {8'h00, $past(cfg.low_period)} && !level_r)
    else $error("low phase reloaded with wrong length");

  equal_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == PG_RUN && cfg.gen_on && cfg.ref_tick && cnt_r == 24'h000000 && cfg.duty_mode
      |=> cnt_r == {$past(cfg.high_period[7:0]), $past(cfg.low_period)})
    else $error("equal duty count not joined");

  count_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == PG_RUN && cfg.gen_on && cfg.ref_tick && cnt_r != 24'h000000
      |=> cnt_r == $past(cnt_r) - 24'h000001 && level_r == $past(level_r))
    else $error("phase counter did not step");

  idle_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == PG_IDLE && !cfg.shot |=> frame_pulse == $past(cfg.idle_level))
    else $error("idle level not driven");

  one_shot_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == PG_IDLE && cfg.shot |=> state_r == PG_SHOT && frame_pulse)
    else $error("one shot did not start");
endmodule // pulse_gen

// ### tb_frame_pulse_and_forwarding_regs.sv
/*
  Self-checking bench for the frame pulse and forwarding register bank.
  Assumes one 40 MHz clock and the AXI4-Lite byte map of fp_cfg.svh.
*/
`include "fp_cfg.svh"
module tb_frame_pulse_and_forwarding_regs import fp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, ref_tick = 0, frame_start = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_v;
  logic [3:0]  wstrb = 0;
  logic        awready, wready, bvalid, arready, rvalid, frame_pulse;
  logic        port0_forward_off, port1_forward_off;
  logic [1:0]  bresp, rresp, tx_rate, rs;
  logic [15:0] frame_number, fexp = 0, lim;
  int          n_mismatch = 0, n_tests = 0, seed = 78, cyc = 0, hi, lo, h, l;
  tx_rate_t    rl[4] = '{RATE_1G6, RATE_800M, RATE_400M, RATE_RSVD};

  frame_pulse_and_forwarding_regs #(.ADDR_W(12)) u_frame_pulse_and_forwarding_regs (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .ref_tick, .frame_start,
    .frame_end(1'b0), .frame_pulse, .frame_number, .tx_rate, .port0_forward_off,
    .port1_forward_off);

  always #12.5 aclk = ~aclk;

  // hang guard: whole run needs well under this
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    // ready rises after the first edge so back-to-back calls never drive it twice at once
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) break;
      bready <= 1;
    end
    rs = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1;
    // no cycle limit here: only the hang guard ends a stuck wait
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) break;
      rready <= 1;
    end
    rd_v = rdata;
    rs = rresp;
    rready <= 0;
  endtask

  // skips any phase already under way so only whole phases are counted
  task automatic meas(output int hc, output int lc);
    int t;
    hc = 0;
    lc = 0;
    for (t = 0; t < 600 && frame_pulse === 1'b1; t++) @(posedge aclk);
    for (t = 0; t < 600 && frame_pulse !== 1'b1; t++) @(posedge aclk);
    while (frame_pulse === 1'b1 && hc < 600) begin hc++; @(posedge aclk); end
    while (frame_pulse === 1'b0 && lc < 600) begin lc++; @(posedge aclk); end
  endtask

  function automatic logic [15:0] fnext(logic [15:0] c, logic [15:0] m);
    if (m == 0) return 16'h0;
    return (c >= m || c == 0) ? 16'h1 : c + 16'h1;
  endfunction

  // read-only reserved bits of the rate and forwarding bytes read back as zero
  function automatic logic [31:0] rmask(int a);
    return a == 'h7C ? 32'h0F : a == 'h80 ? 32'hF0 : 32'hFF;
  endfunction

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(12'h074); chk("limit high", 32'h00, rd_v);
    rd(12'h078); chk("limit low", 32'h04, rd_v);
    rd(12'h07C); chk("rate reg", 32'h02, rd_v);
    rd(12'h080); chk("fwd reg", 32'h30, rd_v);
    chk("outs", 32'hB, {tx_rate, port1_forward_off, port0_forward_off});
    rd(12'h100); chk("unmapped", `RESP_SLVERR, rs);
    wr(12'h100, 8'h55); chk("unmapped wr", `RESP_SLVERR, rs);
    wr(12'h074, 8'h00); chk("wr okay", `RESP_OKAY, rs);
    $display("test reset done");
    wr(12'h07C, 8'hFF); rd(12'h07C); chk("rate rsvd", 32'h0F, rd_v);
    wr(12'h080, 8'hFF); rd(12'h080); chk("fwd rsvd", 32'hF0, rd_v);
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h080, 8'(i << 4)); rd(12'h080); chk("port offs", i, {port1_forward_off, port0_forward_off});
      wr(12'h07C, 8'(rl[i])); rd(12'h07C); chk("tx rate", i == 3 ? RATE_400M : rl[i], tx_rate);
    end
    wr(12'h07C, 8'h02, 4'h0); rd(12'h07C); chk("no strobe", 32'h01, rd_v);
    for (int i = 0; i < 6; i++)
    begin
      h = ($random(seed) & 7) * 4 + 'h64;
      l = $random(seed) & 'hFF;
      wr(12'(h), 8'(l)); rd(12'(h)); chk("byte reg", l & rmask(h), rd_v);
    end
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      lim = i == 0 ? 16'h0 : i == 1 ? 16'h3 : i == 2 ? 16'h0100 : 16'(($random(seed) & 7) + 1);
      wr(12'h074, lim[15:8]);
      wr(12'h078, lim[7:0]);
      repeat (6)
      begin
        frame_start <= 1;
        @(posedge aclk);
        frame_start <= 0;
        @(posedge aclk);
        fexp = fnext(fexp, lim);
        chk("frame number", fexp, frame_number);
      end
    end
    $display("test frame number done");
    ref_tick <= 1;
    h = $random(seed) & 7;
    l = $random(seed) & 7;
    wr(12'h064, 8'h00); wr(12'h068, 8'(h)); wr(12'h06C, 8'h00); wr(12'h070, 8'(l));
    wr(12'h060, 8'h01);
    meas(hi, lo);
    chk("high len", h + 1, hi);
    chk("low len", l + 1, lo);
    // upper high byte must be ignored in equal duty
    wr(12'h064, 8'h01); wr(12'h068, 8'h00); wr(12'h060, 8'h03);
    meas(hi, lo);
    chk("equal high", l + 1, hi);
    chk("equal low", l + 1, lo);
    wr(12'h060, 8'h04); repeat (2) @(posedge aclk); chk("idle one", 1, frame_pulse);
    wr(12'h060, 8'h00); repeat (2) @(posedge aclk); chk("idle zero", 0, frame_pulse);
    wr(12'h064, 8'h00); wr(12'h068, 8'(h)); wr(12'h060, 8'h08);
    meas(hi, lo);
    chk("shot len", h + 1, hi);
    chk("shot once", 600, lo);
    rd(12'h060); chk("shot reads", 32'h00, rd_v);
    $display("test pulse done");
    close_out();
  end
endmodule // tb_frame_pulse_and_forwarding_regs
